// *** hdl/ivpm_sel.sv ***
// priority selector: picks the best eligible pending request
// assumes pending and level inputs are stable flops on the same clock
`timescale 1ns/1ns
`include "ivpm_regs.svh"

module ivpm_sel
  import ivpm_pkg::*;
(
  input wire logic [`IVPM_NUM_RQ-1:0] pend,
  input wire logic [`IVPM_NUM_RQ*`IVPM_LVL_W-1:0] levels,
  input wire ivpm_lvl_t core_lvl,
  output logic hit,
  output ivpm_num_t num,
  output ivpm_lvl_t lvl
);

  logic [`IVPM_NUM_RQ-1:0] elig;

  genvar g;
  generate
    for (g = 0; g < `IVPM_NUM_RQ; g++) begin : g_elig
      // lower code outranks; the core's level 0 masks everything
      assign elig[g] = pend[g] &&
        (levels[g*`IVPM_LVL_W +: `IVPM_LVL_W] < core_lvl);
    end
  endgenerate

  always_comb begin
    hit = 1'b0;
    num = '0;
    lvl = '1;
    // ascending scan with strict compare keeps the lowest number on ties
    for (int i = 0; i < `IVPM_NUM_RQ; i++) begin
      if (elig[i] &&
          (!hit || levels[i*`IVPM_LVL_W +: `IVPM_LVL_W] < lvl)) begin
        hit = 1'b1;
        num = ivpm_num_t'(i);
        lvl = levels[i*`IVPM_LVL_W +: `IVPM_LVL_W];
      end
    end
  end

endmodule

// *** hdl/ivpm_top.sv ***
// interrupt request mapper: gathers peripheral sources onto 24 requests,
// holds the level registers and presents the winning vector to the core
// assumes sources and core level come from logic on mclk, no sync needed
//
// Functional notes
// - every request has its own 2-bit level
// - same level: lowest request number wins
// - ext channels 0,4 on request 0, FFFA/FFFB
// - ext channels 1,5 on request 1, FFF8/FFF9
// - ext channels 2,6 on request 2, FFF6/FFF7
// - ext channels 3,7 on request 3, FFF4/FFF5
// - serial port, dead-time trip share request 4
// - composite timer 0: low 5, high 6
// - composite timer 1: high 14, low 22
// - pulse generator 1: low 9, high 10
// - pulse generator 0: high 12, low 13
// - pulse generator 2: high 11, low 15
// - reload timer, motor write/clear, i2c: 16
// - pulse timer, motor position/match: 17
// - six level registers from 0079, reset ones
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "ivpm_regs.svh"

module ivpm_top
  import ivpm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ivpm_src_t src,
  input wire ivpm_lvl_t core_lvl,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ivpm_vec_t core_out_r,
  output logic [7:0] reg_rdata_r
);

  // ---- request gathering ----
  logic [`IVPM_NUM_RQ-1:0] rq_raw;
  logic [`IVPM_NUM_RQ-1:0] pend_r;
  logic [`IVPM_NUM_RQ-1:0] pend_nxt;

  genvar e;
  generate
    for (e = 0; e < `IVPM_EXT_PAIRS; e++) begin : g_ext
      // channel e and channel e+4 share one request
      assign rq_raw[int'(rq_ext_0_4) + e] =
        src.ext_int_lo[e] | src.ext_int_hi[e];
    end
  endgenerate

  assign rq_raw[rq_serial_dead_time] =
    src.synchronous_serial_port | src.dead_time_trip_input;
  assign rq_raw[rq_ctimer0_lo] = src.ctimer0_lo;
  assign rq_raw[rq_ctimer0_hi] = src.ctimer0_hi;
  assign rq_raw[rq_lin_rx] = src.lin_rx;
  assign rq_raw[rq_lin_tx] = src.lin_tx;
  assign rq_raw[rq_pulse1_lo] = src.prog_pulse1_lo;
  assign rq_raw[rq_pulse1_hi] = src.prog_pulse1_hi;
  assign rq_raw[rq_pulse2_hi] = src.prog_pulse2_hi;
  assign rq_raw[rq_pulse0_hi] = src.prog_pulse0_hi;
  assign rq_raw[rq_pulse0_lo] = src.prog_pulse0_lo;
  assign rq_raw[rq_ctimer1_hi] = src.ctimer1_hi;
  assign rq_raw[rq_pulse2_lo] = src.prog_pulse2_lo;
  assign rq_raw[rq_reload_motor] = src.reload_timer1 |
    src.motor_write_timing | src.motor_compare_clear | src.i2c;
  assign rq_raw[rq_ptimer_motor] = src.pulse_timer1 |
    src.motor_position_detect | src.motor_compare_match;
  assign rq_raw[rq_adc] = src.adc;
  assign rq_raw[rq_timebase] = src.timebase;
  assign rq_raw[rq_watch] = src.watch_prescaler;
  // no source is wired here, so it can never be selected
  assign rq_raw[rq_unused] = 1'b0;
  assign rq_raw[rq_ctimer1_lo] = src.ctimer1_lo;
  assign rq_raw[rq_flash] = src.flash;

  always_comb begin
    pend_nxt = rq_raw;
    if (sys_rst) begin
      pend_nxt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    pend_r <= pend_nxt;
  end

  // ---- level registers ----
  logic [`IVPM_NUM_LVL_REGS-1:0][7:0] lvl_r;
  logic [`IVPM_NUM_LVL_REGS-1:0][7:0] lvl_nxt;
  logic [15:0] lvl_ofs;
  logic lvl_hit;
  logic [2:0] lvl_idx;

  assign lvl_ofs = reg_addr - `IVPM_LVL_BASE;
  assign lvl_hit = (reg_addr >= `IVPM_LVL_BASE) &&
    (lvl_ofs < 16'(`IVPM_NUM_LVL_REGS));
  assign lvl_idx = lvl_ofs[2:0];

  always_comb begin
    lvl_nxt = lvl_r;
    if (sys_rst) begin
      // all ones leaves every request at the weakest level
      lvl_nxt = {`IVPM_NUM_LVL_REGS{`IVPM_LVL_RST}};
    end else if (reg_wr && lvl_hit) begin
      lvl_nxt[lvl_idx] = reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    lvl_r <= lvl_nxt;
  end

  // register k bits 2j+1:2j hold the level of request 4k+j
  logic [`IVPM_NUM_RQ*`IVPM_LVL_W-1:0] lvl_flat;
  assign lvl_flat = lvl_r;

  // ---- selection and core output ----
  logic sel_hit;
  ivpm_num_t sel_num;
  ivpm_lvl_t sel_lvl;

  ivpm_sel u_sel (
    .pend(pend_r),
    .levels(lvl_flat),
    .core_lvl(core_lvl),
    .hit(sel_hit),
    .num(sel_num),
    .lvl(sel_lvl)
  );

  ivpm_vec_t core_nxt;
  logic [15:0] vec_up;

  // entries descend two bytes per request from the top of the table
  assign vec_up = `IVPM_VEC_TOP - {10'h000, sel_num, 1'b0};

  always_comb begin
    core_nxt = '0;
    if (!sys_rst && sel_hit) begin
      core_nxt.valid = 1'b1;
      core_nxt.num = sel_num;
      core_nxt.level = sel_lvl;
      core_nxt.vec_upper = vec_up;
      core_nxt.vec_lower = vec_up + `IVPM_VEC_NEXT;
    end
  end

  always_ff @(posedge mclk) begin
    core_out_r <= core_nxt;
  end

  // ---- register read port ----
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 8'h00;
    if (!sys_rst && reg_rd) begin
      if (lvl_hit) begin
        rdata_nxt = lvl_r[lvl_idx];
      end else begin
        unique case (reg_addr)
          `IVPM_PEND0_ADDR: rdata_nxt = pend_r[7:0];
          `IVPM_PEND1_ADDR: rdata_nxt = pend_r[15:8];
          `IVPM_PEND2_ADDR: rdata_nxt = pend_r[23:16];
          `IVPM_SEL_ADDR: begin
            rdata_nxt = {core_out_r.valid, core_out_r.level,
              core_out_r.num};
          end
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    reg_rdata_r <= rdata_nxt;
  end

endmodule

// *** pkg/ivpm_pkg.sv ***
// types shared by the request mapper and its priority selector
// assumes the constants header sits on the include path
`include "ivpm_regs.svh"

package ivpm_pkg;

  typedef logic [`IVPM_LVL_W-1:0] ivpm_lvl_t;
  typedef logic [`IVPM_RQ_W-1:0] ivpm_num_t;

  // request numbers in table order, 0 = highest fixed precedence
  typedef enum logic [`IVPM_RQ_W-1:0] {
    rq_ext_0_4, rq_ext_1_5, rq_ext_2_6, rq_ext_3_7,
    rq_serial_dead_time, rq_ctimer0_lo, rq_ctimer0_hi,
    rq_lin_rx, rq_lin_tx, rq_pulse1_lo, rq_pulse1_hi,
    rq_pulse2_hi, rq_pulse0_hi, rq_pulse0_lo, rq_ctimer1_hi,
    rq_pulse2_lo, rq_reload_motor, rq_ptimer_motor, rq_adc,
    rq_timebase, rq_watch, rq_unused, rq_ctimer1_lo, rq_flash
  } ivpm_rq_t;

  // one level request from each peripheral source, held until serviced
  typedef struct packed {
    logic [`IVPM_EXT_PAIRS-1:0] ext_int_lo;
    logic [`IVPM_EXT_PAIRS-1:0] ext_int_hi;
    logic synchronous_serial_port;
    logic dead_time_trip_input;
    logic ctimer0_lo;
    logic ctimer0_hi;
    logic lin_rx;
    logic lin_tx;
    logic prog_pulse1_lo;
    logic prog_pulse1_hi;
    logic prog_pulse2_hi;
    logic prog_pulse2_lo;
    logic prog_pulse0_hi;
    logic prog_pulse0_lo;
    logic ctimer1_hi;
    logic ctimer1_lo;
    logic reload_timer1;
    logic motor_write_timing;
    logic motor_compare_clear;
    logic i2c;
    logic pulse_timer1;
    logic motor_position_detect;
    logic motor_compare_match;
    logic adc;
    logic timebase;
    logic watch_prescaler;
    logic flash;
  } ivpm_src_t;

  // what the core sees: winner, its level and its vector byte addresses
  typedef struct packed {
    logic valid;
    ivpm_num_t num;
    ivpm_lvl_t level;
    logic [15:0] vec_upper;
    logic [15:0] vec_lower;
  } ivpm_vec_t;

endpackage

// *** pkg/ivpm_regs.svh ***
// named offsets, reset values and counts of the request mapper
// assumes it is included by bare name from the package and the design files
`ifndef IVPM_REGS_SVH
`define IVPM_REGS_SVH

`define IVPM_NUM_RQ 24
`define IVPM_RQ_W 5
`define IVPM_LVL_W 2
`define IVPM_FLD_PER_REG 4
`define IVPM_NUM_LVL_REGS 6
`define IVPM_EXT_PAIRS 4

`define IVPM_LVL_BASE 16'h0079
`define IVPM_LVL_RST 8'hFF

`define IVPM_PEND0_ADDR 16'h00F0
`define IVPM_PEND1_ADDR 16'h00F1
`define IVPM_PEND2_ADDR 16'h00F2
`define IVPM_SEL_ADDR 16'h00F3

`define IVPM_VEC_TOP 16'hFFFA
`define IVPM_VEC_NEXT 16'h0001

`endif

// *** verif/ivpm_core.sv ***
// behavioural core: follows a requested level, records vectors taken
// assumes the bench sets the wanted level on mclk
`timescale 1ns/1ns
module ivpm_core
  import ivpm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ivpm_lvl_t want,
  input wire ivpm_vec_t vec,
  output ivpm_lvl_t core_lvl,
  output logic [15:0] taken
);
  // level 0 at reset keeps every request masked until software runs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      core_lvl <= 2'h0;
      taken <= 16'h0000;
    end else begin
      core_lvl <= want;
      if (vec.valid) begin
        taken <= vec.vec_upper;
      end
    end
  end
endmodule

// *** verif/ivpm_top_asserts.sv ***
// checker for the request mapper, watching only the top ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module ivpm_top_chk
  import ivpm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ivpm_src_t src,
  input wire ivpm_lvl_t core_lvl,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ivpm_vec_t core_out_r,
  input wire logic [7:0] reg_rdata_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_up;
    core_out_r.valid |-> core_out_r.vec_upper ==
      16'hFFFA - {10'h000, core_out_r.num, 1'b0};
  endproperty
  a_up: assert property (p_up) else $error("upper vector wrong");
  property p_lo;
    core_out_r.valid |->
      core_out_r.vec_lower == core_out_r.vec_upper + 16'h0001;
  endproperty
  a_lo: assert property (p_lo) else $error("lower vector wrong");
  property p_no21;
    !(core_out_r.valid && core_out_r.num == 5'h15);
  endproperty
  a_no21: assert property (p_no21) else $error("empty request shown");
  property p_elig;
    core_out_r.valid |-> core_out_r.level < $past(core_lvl);
  endproperty
  a_elig: assert property (p_elig) else $error("level not eligible");
  property p_mask;
    core_lvl == 2'h0 |=> !core_out_r.valid;
  endproperty
  a_mask: assert property (p_mask) else $error("masked but shown");
  property p_ext0;
    core_out_r.valid && core_out_r.num == 5'h00 |->
      $past(src.ext_int_lo[0] | src.ext_int_hi[0], 2);
  endproperty
  a_ext0: assert property (p_ext0) else $error("request 0 no cause");
  property p_wrrd;
    reg_wr && reg_addr inside {[16'h0079:16'h007E]} ##1
      reg_rd && reg_addr == $past(reg_addr) |=>
      reg_rdata_r == $past(reg_wdata, 2);
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("level reg readback");
  property p_unmap;
    reg_rd && reg_addr == 16'h007F |=> reg_rdata_r == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind ivpm_top ivpm_top_chk chk_u(.mclk, .sys_rst, .src, .core_lvl,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .core_out_r, .reg_rdata_r);

// *** verif/tb.sv ***
// self-checking bench for the request mapper
// assumes a 100 ns mclk and the core model on the far side
`timescale 1ns/1ns
module tb;
  import ivpm_pkg::*;
  logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [32:0] src = '0;
  ivpm_lvl_t want = 2'h3;
  ivpm_lvl_t core_lvl;
  logic [15:0] reg_addr = '0, taken;
  logic [7:0] reg_wdata = '0, reg_rdata_r;
  ivpm_vec_t vo;
  int err_count = 0, comparisons = 0, cyc = 0;
  // expected request number for each source bit, lsb of the struct first
  byte exp_num [33] = '{23, 20, 19, 18, 17, 17, 17, 16, 16, 16, 16, 22, 14,
    13, 12, 15, 11, 10, 9, 8, 7, 6, 5, 4, 4, 0, 1, 2, 3, 0, 1, 2, 3};
  always #50 mclk = ~mclk;
  ivpm_top dut_u(.mclk(mclk), .sys_rst(sys_rst), .src(src),
    .core_lvl(core_lvl), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .core_out_r(vo),
    .reg_rdata_r(reg_rdata_r));
  ivpm_core core_u(.mclk(mclk), .sys_rst(sys_rst), .want(want), .vec(vo),
    .core_lvl(core_lvl), .taken(taken));
  task wrap_up;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // now skips the leading edge so a read can follow a write back to back
  task rd(input logic [15:0] a, input logic [7:0] e, input bit now);
    if (!now) @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata_r});
  endtask
  task vec(input logic v, input logic [4:0] n, input ivpm_lvl_t l);
    logic [15:0] up;
    up = 16'hFFFA - {10'h000, n, 1'b0};
    repeat (3) @(posedge mclk);
    #1 chk("valid", {15'h0000, v}, {15'h0000, vo.valid});
    if (v) begin
      chk("num", {11'h000, n}, {11'h000, vo.num});
      chk("level", {14'h0000, l}, {14'h0000, vo.level});
      chk("upper", up, vo.vec_upper);
      chk("lower", up + 16'h0001, vo.vec_lower);
    end
    // finish on an edge so the next stimulus is launched by it
    @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(16'h0079 + 16'(i), 8'hFF, 0);
    rd(16'h007F, 8'h00, 0);
    wr(16'h007A, 8'hE4);
    rd(16'h007A, 8'hE4, 1);
    for (int i = 0; i < 6; i++)
      wr(16'h0079 + 16'(i), 8'h00);
    for (int i = 0; i < 33; i++) begin
      logic [4:0] n;
      n = 5'(exp_num[i]);
      src <= 33'h1 << i;
      if (i < 11) vec(1, n, 2'h0);
      else if (i < 17) vec(1, n, 2'h0);
      else if (i < 25) vec(1, n, 2'h0);
      else vec(1, n, 2'h0);
    end
    src <= '1;
    vec(1, 5'd0, 2'h0);
    // request 21 has no source, so its pending bit must stay clear
    rd(16'h00F0, 8'hFF, 0);
    rd(16'h00F1, 8'hFF, 0);
    rd(16'h00F2, 8'hDF, 0);
    rd(16'h00F3, 8'h80, 0);
    for (int i = 0; i < 6; i++)
      wr(16'h0079 + 16'(i), 8'hFF);
    vec(0, 5'd0, 2'h0);
    // register 4 holds requests 16..19, request 19 in bits 7:6
    wr(16'h007D, 8'hBF);
    vec(1, 5'd19, 2'h2);
    wr(16'h007D, 8'hBD);
    vec(1, 5'd16, 2'h1);
    chk("taken", 16'hFFDA, taken);
    want <= 2'h1;
    vec(0, 5'd0, 2'h0);
    wr(16'h007E, 8'h3F);
    vec(1, 5'd23, 2'h0);
    want <= 2'h0;
    vec(0, 5'd0, 2'h0);
    // mid-run reset must bring every level field back to ones
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(16'h007E, 8'hFF, 0);
    rd(16'h007D, 8'hFF, 0);
    wrap_up;
  end
endmodule
